// *** inc/string_engine_defines.vh ***
// constants for the byte-string move, match and translate engine
//
// Contract
// - match opcode searches substring, sets zero flag
// - on match: counts, pointers past match
// - no match: object length, addresses, source end
// - empty object acts as found, zero set
// - empty source only: acts as not found
// - three-operand move direction avoids overlap corruption
// - three-operand move: pointers past, counts zero
// - five-operand move copies minimum, fills remainder
// - descending: fill top first, then copy down
// - five-operand move result registers
// - flags compare source and destination lengths
// - translate through 256-byte table, with fill
// - translate result registers, table in second pointer
// - translate-until stops at escape or exhaustion
// - overflow flag set only on escape stop
// - zero length skips translate-until loop
// - translate-until counts left, table address
// - zero length string makes no memory access
`ifndef STRING_ENGINE_DEFINES_VH
`define STRING_ENGINE_DEFINES_VH

`define SE_OP_MATCH 8'h39
`define SE_OP_MOVE3 8'h28
`define SE_OP_MOVE5 8'h2C
`define SE_OP_XLATE 8'h2E
`define SE_OP_XUNTIL 8'h2F

`define SE_A_CMD 8'h00
`define SE_A_STATUS 8'h04
`define SE_A_LEN1 8'h08
`define SE_A_ADDR1 8'h0C
`define SE_A_CHAR 8'h10
`define SE_A_TABLE 8'h14
`define SE_A_LEN2 8'h18
`define SE_A_ADDR2 8'h1C
`define SE_A_RES0 8'h20
`define SE_A_RES1 8'h24
`define SE_A_RES2 8'h28
`define SE_A_RES3 8'h2C
`define SE_A_RES4 8'h30
`define SE_A_RES5 8'h34
`define SE_A_FLAGS 8'h38

`define SE_ST_BUSY 0
`define SE_ST_BADOP 1
`define SE_FL_C 0
`define SE_FL_V 1
`define SE_FL_Z 2
`define SE_FL_N 3

`define SE_RESP_OKAY 2'b00
`define SE_RESP_SLVERR 2'b10

`endif

// *** src/len_flags.v ***
// condition flags from comparing two string lengths
`timescale 1ns/1ns
module len_flags #(
	parameter W = 16
) (
	input wire [W-1:0] a,
	input wire [W-1:0] b,
	output wire n,
	output wire z,
	output wire c
);
	assign n = $signed(a) < $signed(b);
	assign z = a == b;
	assign c = a < b;
endmodule // len_flags

// *** src/string_engine.v ***
// byte-string move, match and translate engine with axi4-lite registers
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "string_engine_defines.vh"
module string_engine #(
	parameter LW = 16,
	parameter AW = 32
) (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg mem_req_q,
	output reg mem_we_q,
	output reg [AW-1:0] mem_addr_q,
	output reg [7:0] mem_wdata_q,
	input wire [7:0] mem_rdata,
	input wire mem_ack
);
	localparam [6:0] ST_IDLE = 7'h01;
	localparam [6:0] ST_NEXT = 7'h02;
	localparam [6:0] ST_OBJ = 7'h04;
	localparam [6:0] ST_SRC = 7'h08;
	localparam [6:0] ST_TBL = 7'h10;
	localparam [6:0] ST_WR = 7'h20;
	localparam [6:0] ST_FIN = 7'h40;

	// ==========================================================
	// operand and result registers
	reg [7:0] op_q;
	reg [LW-1:0] len1_q;
	reg [AW-1:0] addr1_q;
	reg [7:0] chr_q;
	reg [AW-1:0] tbl_q;
	reg [LW-1:0] len2_q;
	reg [AW-1:0] addr2_q;
	reg [AW-1:0] res_q [0:5];
	reg [3:0] flags_q;
	reg start_q;
	reg badop_q;
	reg [7:0] waddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	reg aw_hold_q;
	reg w_hold_q;
	reg [6:0] st_q;
	reg [LW-1:0] t1_q;
	reg [AW-1:0] t2_q;
	reg [LW-1:0] t3_q;
	reg [AW-1:0] t4_q;
	reg [7:0] d_q;
	reg [7:0] o_q;
	reg desc_q;
	reg filling_q;
	reg esc_q;
	wire busy;
	wire is_match;
	wire is_until;
	wire is_move3;
	wire is_xlate;
	wire [LW-1:0] l2;
	wire [LW-1:0] mn;
	wire [LW-1:0] k;
	wire fn;
	wire fz;
	wire fc;
	wire wr_ok;
	wire op_ok;
	wire [31:0] len1_m;
	wire [31:0] len2_m;
	reg [AW-1:0] acc_addr;
	reg [31:0] rd_mux;
	reg rd_ok;
	integer i;

	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] be;
		integer b;
		begin
			merge = old;
			for (b = 0; b < 4; b = b + 1) begin
				if (be[b])
					merge[8*b +: 8] = nw[8*b +: 8];
			end
		end
	endfunction

	assign busy = (st_q != ST_IDLE) | start_q;
	assign is_match = op_q == `SE_OP_MATCH;
	assign is_until = op_q == `SE_OP_XUNTIL;
	assign is_move3 = op_q == `SE_OP_MOVE3;
	assign is_xlate = op_q == `SE_OP_XLATE;
	// the three-operand move copies len1 bytes into len1 bytes
	assign l2 = is_move3 ? len1_q : len2_q;
	assign mn = (len1_q < l2) ? len1_q : l2;
	assign k = len1_q - t1_q;
	assign len1_m = merge({16'h0000, len1_q}, wdata_q, wstrb_q);
	assign len2_m = merge({16'h0000, len2_q}, wdata_q, wstrb_q);
	assign op_ok = (wdata_q[7:0] == `SE_OP_MATCH) |
		(wdata_q[7:0] == `SE_OP_MOVE3) |
		(wdata_q[7:0] == `SE_OP_MOVE5) |
		(wdata_q[7:0] == `SE_OP_XLATE) |
		(wdata_q[7:0] == `SE_OP_XUNTIL);
	assign wr_ok = !busy && (waddr_q == `SE_A_CMD ||
		(waddr_q >= `SE_A_LEN1 && waddr_q <= `SE_A_ADDR2 &&
		waddr_q[1:0] == 2'b00));

	len_flags #(
		.W(LW)
	) u_len_flags (
		.a(len1_q),
		.b(l2),
		.n(fn),
		.z(fz),
		.c(fc)
	);

	// ==========================================================
	// axi4-lite write channel and register writes
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SE_RESP_OKAY;
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			waddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			op_q <= 8'h00;
			len1_q <= 16'h0000;
			addr1_q <= 32'h0000_0000;
			chr_q <= 8'h00;
			tbl_q <= 32'h0000_0000;
			len2_q <= 16'h0000;
			addr2_q <= 32'h0000_0000;
			start_q <= 1'b0;
			badop_q <= 1'b0;
		end else begin
			start_q <= 1'b0;
			if (s_axi_awvalid && s_axi_awready) begin
				waddr_q <= s_axi_awaddr;
				aw_hold_q <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				w_hold_q <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (aw_hold_q && w_hold_q && !s_axi_bvalid) begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `SE_RESP_OKAY : `SE_RESP_SLVERR;
				if (wr_ok) begin
					case (waddr_q)
					`SE_A_CMD: begin
						if (wstrb_q[0] && op_ok) begin
							op_q <= wdata_q[7:0];
							start_q <= 1'b1;
							badop_q <= 1'b0;
						end else if (wstrb_q[0]) begin
							badop_q <= 1'b1;
						end
					end
					`SE_A_LEN1: len1_q <= len1_m[LW-1:0];
					`SE_A_ADDR1: addr1_q <= merge(addr1_q, wdata_q, wstrb_q);
					`SE_A_CHAR: begin
						if (wstrb_q[0])
							chr_q <= wdata_q[7:0];
					end
					`SE_A_TABLE: tbl_q <= merge(tbl_q, wdata_q, wstrb_q);
					`SE_A_LEN2: len2_q <= len2_m[LW-1:0];
					`SE_A_ADDR2: addr2_q <= merge(addr2_q, wdata_q, wstrb_q);
					default: ;
					endcase
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ==========================================================
	// axi4-lite read channel
	always @* begin
		rd_ok = 1'b1;
		rd_mux = 32'h0000_0000;
		case (s_axi_araddr)
		`SE_A_CMD: rd_mux = {24'h00_0000, op_q};
		`SE_A_STATUS: rd_mux = {30'h0000_0000, badop_q, busy};
		`SE_A_LEN1: rd_mux = {16'h0000, len1_q};
		`SE_A_ADDR1: rd_mux = addr1_q;
		`SE_A_CHAR: rd_mux = {24'h00_0000, chr_q};
		`SE_A_TABLE: rd_mux = tbl_q;
		`SE_A_LEN2: rd_mux = {16'h0000, len2_q};
		`SE_A_ADDR2: rd_mux = addr2_q;
		`SE_A_RES0: rd_mux = res_q[0];
		`SE_A_RES1: rd_mux = res_q[1];
		`SE_A_RES2: rd_mux = res_q[2];
		`SE_A_RES3: rd_mux = res_q[3];
		`SE_A_RES4: rd_mux = res_q[4];
		`SE_A_RES5: rd_mux = res_q[5];
		`SE_A_FLAGS: rd_mux = {28'h000_0000, flags_q};
		default: rd_ok = 1'b0;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `SE_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mux;
			s_axi_rresp <= rd_ok ? `SE_RESP_OKAY : `SE_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ==========================================================
	// string engine
	always @* begin
		acc_addr = t4_q;
		case (st_q)
		ST_OBJ: acc_addr = t2_q;
		ST_SRC: acc_addr = is_match ? t4_q : t2_q;
		ST_TBL: acc_addr = tbl_q + {24'h00_0000, d_q};
		default: acc_addr = t4_q;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= ST_IDLE;
			mem_req_q <= 1'b0;
			mem_we_q <= 1'b0;
			mem_addr_q <= 32'h0000_0000;
			mem_wdata_q <= 8'h00;
			t1_q <= 16'h0000;
			t2_q <= 32'h0000_0000;
			t3_q <= 16'h0000;
			t4_q <= 32'h0000_0000;
			d_q <= 8'h00;
			o_q <= 8'h00;
			desc_q <= 1'b0;
			filling_q <= 1'b0;
			esc_q <= 1'b0;
			flags_q <= 4'h0;
			for (i = 0; i < 6; i = i + 1)
				res_q[i] <= 32'h0000_0000;
		end else begin
			case (st_q)
			ST_IDLE: begin
				if (start_q) begin
					st_q <= ST_NEXT;
					esc_q <= 1'b0;
					if (is_match || is_until) begin
						desc_q <= 1'b0;
						filling_q <= 1'b0;
						t1_q <= len1_q;
						t2_q <= addr1_q;
						t3_q <= len2_q;
						t4_q <= addr2_q;
					end else if (addr1_q > addr2_q) begin
						desc_q <= 1'b0;
						filling_q <= 1'b0;
						t1_q <= mn;
						t2_q <= addr1_q;
						t3_q <= l2 - mn;
						t4_q <= addr2_q;
					end else begin
						desc_q <= 1'b1;
						filling_q <= 1'b1;
						t1_q <= mn;
						t2_q <= addr1_q + {16'h0000, mn} - 32'h0000_0001;
						t3_q <= l2 - mn;
						t4_q <= addr2_q + {16'h0000, l2} - 32'h0000_0001;
					end
				end
			end
			ST_NEXT: begin
				if (is_match) begin
					if (t1_q != 16'h0000 && t3_q >= t1_q)
						st_q <= ST_OBJ;
					else
						st_q <= ST_FIN;
				end else if (is_until) begin
					if (t1_q != 16'h0000 && t3_q != 16'h0000)
						st_q <= ST_SRC;
					else
						st_q <= ST_FIN;
				end else if (filling_q) begin
					if (t3_q == 16'h0000) begin
						if (desc_q)
							filling_q <= 1'b0;
						else
							st_q <= ST_FIN;
					end else begin
						st_q <= ST_WR;
					end
				end else begin
					if (t1_q == 16'h0000) begin
						if (desc_q)
							st_q <= ST_FIN;
						else
							filling_q <= 1'b1;
					end else begin
						st_q <= ST_SRC;
					end
				end
			end
			ST_OBJ, ST_SRC, ST_TBL, ST_WR: begin
				if (!mem_req_q) begin
					mem_req_q <= 1'b1;
					mem_we_q <= st_q == ST_WR;
					mem_addr_q <= acc_addr;
					mem_wdata_q <= filling_q ? chr_q : d_q;
				end else if (mem_ack) begin
					mem_req_q <= 1'b0;
					mem_we_q <= 1'b0;
					case (st_q)
					ST_OBJ: begin
						o_q <= mem_rdata;
						st_q <= ST_SRC;
					end
					ST_SRC: begin
						d_q <= mem_rdata;
						if (is_match) begin
							st_q <= ST_NEXT;
							if (mem_rdata == o_q) begin
								t1_q <= t1_q - 16'h0001;
								t2_q <= t2_q + 32'h0000_0001;
								t3_q <= t3_q - 16'h0001;
								t4_q <= t4_q + 32'h0000_0001;
							end else begin
								// restart one byte further into the source
								t1_q <= len1_q;
								t2_q <= t2_q - {16'h0000, k};
								t3_q <= t3_q - 16'h0001 + k;
								t4_q <= t4_q + 32'h0000_0001 - {16'h0000, k};
							end
						end else if (is_move3 || op_q == `SE_OP_MOVE5) begin
							st_q <= ST_WR;
						end else begin
							st_q <= ST_TBL;
						end
					end
					ST_TBL: begin
						d_q <= mem_rdata;
						if (is_until && mem_rdata == chr_q) begin
							esc_q <= 1'b1;
							st_q <= ST_FIN;
						end else begin
							st_q <= ST_WR;
						end
					end
					default: begin
						st_q <= ST_NEXT;
						if (filling_q) begin
							t3_q <= t3_q - 16'h0001;
						end else begin
							t1_q <= t1_q - 16'h0001;
							t2_q <= desc_q ? t2_q - 32'h0000_0001 :
								t2_q + 32'h0000_0001;
							if (is_until)
								t3_q <= t3_q - 16'h0001;
						end
						t4_q <= desc_q ? t4_q - 32'h0000_0001 :
							t4_q + 32'h0000_0001;
					end
					endcase
				end
			end
			ST_FIN: begin
				st_q <= ST_IDLE;
				if (is_match) begin
					res_q[0] <= {16'h0000, t1_q};
					res_q[1] <= t2_q;
					res_q[2] <= (t3_q < t1_q) ? 32'h0000_0000 :
						{16'h0000, t3_q};
					res_q[3] <= (t3_q < t1_q) ? t4_q + {16'h0000, t3_q} : t4_q;
					res_q[4] <= res_q[4];
					res_q[5] <= res_q[5];
					flags_q <= {1'b0, t1_q == 16'h0000, 2'b00};
				end else if (is_until) begin
					res_q[0] <= {16'h0000, t1_q};
					res_q[1] <= t2_q;
					res_q[2] <= 32'h0000_0000;
					res_q[3] <= tbl_q;
					res_q[4] <= {16'h0000, t3_q};
					res_q[5] <= t4_q;
					flags_q <= {fn, fz, esc_q, fc};
				end else begin
					res_q[0] <= {16'h0000, len1_q - mn};
					res_q[1] <= addr1_q + {16'h0000, mn};
					res_q[2] <= 32'h0000_0000;
					res_q[3] <= is_xlate ? tbl_q : addr2_q + {16'h0000, l2};
					res_q[4] <= 32'h0000_0000;
					res_q[5] <= is_xlate ? addr2_q + {16'h0000, l2} :
						32'h0000_0000;
					flags_q <= {fn, fz, 1'b0, fc};
				end
			end
			default: st_q <= ST_IDLE;
			endcase
		end
	end
endmodule // string_engine

// *** tb/byte_memory.sv ***
// byte-wide memory model answering the engine's memory port
`timescale 1ns/1ns
module byte_memory (
	input wire aclk,
	input wire mem_req_q,
	input wire mem_we_q,
	input wire [31:0] mem_addr_q,
	input wire [7:0] mem_wdata_q,
	output reg [7:0] mem_rdata,
	output reg mem_ack
);
reg [7:0] m [0:1023];
reg [1:0] wait_q = 2'h0;
reg slow_q = 1'b0;
integer n_acc = 0;
initial begin
	mem_rdata = 8'h0;
	mem_ack = 1'b0;
end
// latency alternates between one and three cycles
always @(posedge aclk) begin
	mem_ack <= 1'b0;
	// read lines carry no valid byte outside an answer
	mem_rdata <= ~mem_rdata;
	if (mem_req_q && !mem_ack) begin
		if (wait_q != 2'h0) begin
			wait_q <= wait_q - 2'h1;
		end else begin
			mem_ack <= 1'b1;
			n_acc <= n_acc + 1;
			slow_q <= ~slow_q;
			wait_q <= slow_q ? 2'h0 : 2'h2;
			if (mem_we_q)
				m[mem_addr_q[9:0]] <= mem_wdata_q;
			else
				mem_rdata <= m[mem_addr_q[9:0]];
		end
	end
end
endmodule // byte_memory

// *** tb/string_engine_assertions.sv ***
// checker on the engine's register bus and memory port
`timescale 1ns/1ns
module string_engine_assertions #(
	parameter AW = 32
) (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire mem_req_q,
	input wire mem_we_q,
	input wire [AW-1:0] mem_addr_q,
	input wire [7:0] mem_wdata_q,
	input wire mem_ack
);
default clocking cb @(posedge aclk); endclocking
default disable iff (!aresetn);
// ==========================================
// memory port
a_req_hold:
assert property (mem_req_q && !mem_ack |=> mem_req_q && $stable(mem_addr_q)
	&& $stable(mem_we_q) && $stable(mem_wdata_q))
	else $error("memory request changed before ack");
a_req_gap:
assert property (mem_req_q && mem_ack |=> !mem_req_q)
	else $error("memory request not dropped after ack");
// ==========================================
// register bus
a_write_answer:
assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
	&& s_axi_wready |-> ##2 s_axi_bvalid)
	else $error("write response late");
a_write_blocked:
assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
	else $error("write channels open during response");
a_write_reopen:
assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid
	&& s_axi_awready && s_axi_wready)
	else $error("write channels not reopened");
a_bad_write:
assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
	&& s_axi_wready && (s_axi_awaddr[1:0] != 2'h0
	|| s_axi_awaddr >= 8'h20) |-> ##2 s_axi_bresp == 2'h2)
	else $error("bad write address not refused");
a_read_answer:
assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
	&& !s_axi_arready)
	else $error("read data late");
a_read_unmapped:
assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h38
	|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
	else $error("unmapped read not refused");
a_read_close:
assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid
	&& s_axi_arready)
	else $error("read channel not reopened");
endmodule // string_engine_assertions
bind string_engine string_engine_assertions #(.AW(AW))
	string_engine_assertions_i (.aclk, .aresetn, .s_axi_awaddr,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .mem_req_q, .mem_we_q, .mem_addr_q,
	.mem_wdata_q, .mem_ack);

// *** tb/test_string_engine.sv ***
// self-checking bench for the string engine
`timescale 1ns/1ns
module test_string_engine;
reg aclk = 1'b0;
reg aresetn = 1'b0;
reg [7:0] s_axi_awaddr = 8'h0;
reg s_axi_awvalid = 1'b0;
reg [31:0] s_axi_wdata = 32'h0;
reg [3:0] s_axi_wstrb = 4'hF;
reg s_axi_wvalid = 1'b0;
reg s_axi_bready = 1'b0;
reg [7:0] s_axi_araddr = 8'h0;
reg s_axi_arvalid = 1'b0;
reg s_axi_rready = 1'b0;
wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
wire [1:0] s_axi_bresp, s_axi_rresp;
wire [31:0] s_axi_rdata, mem_addr_q;
wire mem_req_q, mem_we_q, mem_ack;
wire [7:0] mem_wdata_q, mem_rdata;
reg [31:0] rv;
reg [1:0] rr;
integer miscompares = 0;
integer n_checks = 0;
integer cycles = 0;
integer i, k;
always #25 aclk = ~aclk;
string_engine string_engine_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
	.mem_req_q, .mem_we_q, .mem_addr_q, .mem_wdata_q, .mem_rdata, .mem_ack);
byte_memory byte_memory_i (.aclk, .mem_req_q, .mem_we_q, .mem_addr_q,
	.mem_wdata_q, .mem_rdata, .mem_ack);
// ==========================================
// helpers
task chk(input [31:0] got, input [31:0] exp);
	n_checks = n_checks + 1;
	if (got !== exp) begin
		miscompares = miscompares + 1;
		$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
	end
endtask
task results;
	$display("checks %0d miscompares %0d", n_checks, miscompares);
	if (miscompares == 0 && n_checks > 0)
		$display("Regression OK");
	else
		$display("Regression broken");
	$finish;
endtask
task wr(input [7:0] a, input [31:0] d);
	@(posedge aclk);
	s_axi_awaddr <= a;
	s_axi_wdata <= d;
	s_axi_awvalid <= 1'b1;
	s_axi_wvalid <= 1'b1;
	s_axi_bready <= 1'b1;
	do begin
		@(posedge aclk);
		if (s_axi_awready)
			s_axi_awvalid <= 1'b0;
		if (s_axi_wready)
			s_axi_wvalid <= 1'b0;
	end while (!s_axi_bvalid);
	rr = s_axi_bresp;
	s_axi_bready <= 1'b0;
endtask
task rd(input [7:0] a);
	@(posedge aclk);
	s_axi_araddr <= a;
	s_axi_arvalid <= 1'b1;
	s_axi_rready <= 1'b1;
	do begin
		@(posedge aclk);
		if (s_axi_arready)
			s_axi_arvalid <= 1'b0;
	end while (!s_axi_rvalid);
	rv = s_axi_rdata;
	rr = s_axi_rresp;
	s_axi_rready <= 1'b0;
endtask
task rc(input [7:0] a, input [31:0] e);
	rd(a);
	chk(rv, e);
endtask
task mc(input [9:0] a, input [7:0] e);
	chk({24'h0, byte_memory_i.m[a]}, {24'h0, e});
endtask
task run(input [7:0] op, input [15:0] l1, input [31:0] a1, input [7:0] c,
	input [15:0] l2, input [31:0] a2);
	wr(8'h08, {16'h0, l1});
	wr(8'h0C, a1);
	wr(8'h10, {24'h0, c});
	wr(8'h14, 32'h100);
	wr(8'h18, {16'h0, l2});
	wr(8'h1C, a2);
	wr(8'h00, {24'h0, op});
	rv = 32'h1;
	while (rv[0])
		rd(8'h04);
endtask
// results 0..3 then flags n z v c
task res(input [31:0] e0, e1, e2, e3, input [3:0] f);
	rc(8'h20, e0);
	rc(8'h24, e1);
	rc(8'h28, e2);
	rc(8'h2C, e3);
	rc(8'h38, {28'h0, f});
endtask
always @(posedge aclk) begin
	cycles <= cycles + 1;
	if (cycles == 20000) begin
		miscompares = miscompares + 1;
		results;
	end
end
// ==========================================
// tests
initial begin
	for (i = 0; i < 256; i = i + 1) begin
		byte_memory_i.m[i] = i[7:0];
		byte_memory_i.m[i + 256] = i[7:0] ^ 8'h5A;
	end
	byte_memory_i.m[10'hC0] = 8'hB2;
	byte_memory_i.m[10'hC1] = 8'hB3;
	repeat (20) @(posedge aclk);
	aresetn <= 1'b1;
	wr(8'h08, 32'hFFFF_1234);
	rc(8'h08, 32'h0000_1234);
	wr(8'h0C, 32'h1111_1111);
	s_axi_wstrb <= 4'h2;
	wr(8'h0C, 32'h2222_2222);
	s_axi_wstrb <= 4'hF;
	rc(8'h0C, 32'h1111_2211);
	rd(8'h3C);
	chk(rr, 2'h2);
	wr(8'h20, 32'h1);
	chk(rr, 2'h2);
	wr(8'h09, 32'h1);
	chk(rr, 2'h2);
	wr(8'h00, 32'h55);
	rc(8'h04, 32'h2);
	$display("test registers done");
	run(8'h28, 16'h4, 32'h10, 8'h0, 16'h0, 32'h12);
	for (i = 0; i < 4; i = i + 1) mc(10'h12 + i[9:0], 8'h10 + i[7:0]);
	res(32'h0, 32'h14, 32'h0, 32'h16, 4'h4);
	rc(8'h30, 32'h0);
	rc(8'h34, 32'h0);
	rc(8'h04, 32'h0);
	run(8'h28, 16'h4, 32'h32, 8'h0, 16'h0, 32'h30);
	for (i = 0; i < 4; i = i + 1) mc(10'h30 + i[9:0], 8'h32 + i[7:0]);
	$display("test move3 done");
	run(8'h2C, 16'h2, 32'h40, 8'hAA, 16'h5, 32'h50);
	mc(10'h50, 8'h40);
	mc(10'h51, 8'h41);
	for (i = 2; i < 5; i = i + 1) mc(10'h50 + i[9:0], 8'hAA);
	mc(10'h55, 8'h55);
	res(32'h0, 32'h42, 32'h0, 32'h55, 4'h9);
	rc(8'h34, 32'h0);
	run(8'h2C, 16'h5, 32'h60, 8'hAA, 16'h2, 32'h58);
	mc(10'h58, 8'h60);
	mc(10'h59, 8'h61);
	mc(10'h5A, 8'h5A);
	res(32'h3, 32'h62, 32'h0, 32'h5A, 4'h0);
	$display("test move5 done");
	run(8'h2E, 16'h3, 32'h70, 8'hEE, 16'h4, 32'h78);
	mc(10'h78, 8'h2A);
	mc(10'h79, 8'h2B);
	mc(10'h7A, 8'h28);
	mc(10'h7B, 8'hEE);
	res(32'h0, 32'h73, 32'h0, 32'h100, 4'h9);
	rc(8'h30, 32'h0);
	rc(8'h34, 32'h7C);
	run(8'h2E, 16'h3, 32'hD0, 8'hEE, 16'h2, 32'hC8);
	mc(10'hC8, 8'h8A);
	mc(10'hC9, 8'h8B);
	mc(10'hCA, 8'hCA);
	res(32'h1, 32'hD2, 32'h0, 32'h100, 4'h0);
	rc(8'h34, 32'hCA);
	$display("test translate done");
	run(8'h2F, 16'h4, 32'h80, 8'hD8, 16'h4, 32'h88);
	mc(10'h88, 8'hDA);
	mc(10'h89, 8'hDB);
	mc(10'h8A, 8'h8A);
	res(32'h2, 32'h82, 32'h0, 32'h100, 4'h6);
	rc(8'h30, 32'h2);
	rc(8'h34, 32'h8A);
	run(8'h2F, 16'h2, 32'h90, 8'h0, 16'h3, 32'h98);
	mc(10'h98, 8'hCA);
	mc(10'h9A, 8'h9A);
	res(32'h0, 32'h92, 32'h0, 32'h100, 4'h9);
	rc(8'h30, 32'h1);
	k = byte_memory_i.n_acc;
	run(8'h2F, 16'h0, 32'hA0, 8'h0, 16'h3, 32'hA8);
	chk(byte_memory_i.n_acc, k);
	res(32'h0, 32'hA0, 32'h0, 32'h100, 4'h9);
	rc(8'h30, 32'h3);
	rc(8'h34, 32'hA8);
	run(8'h2F, 16'h2, 32'hE0, 8'h0, 16'h2, 32'hE0);
	mc(10'hE0, 8'hBA);
	mc(10'hE1, 8'hBB);
	res(32'h0, 32'hE2, 32'h0, 32'h100, 4'h4);
	rc(8'h34, 32'hE2);
	$display("test translate until done");
	run(8'h39, 16'h2, 32'hC0, 8'h0, 16'h6, 32'hB0);
	res(32'h0, 32'hC2, 32'h2, 32'hB4, 4'h4);
	byte_memory_i.m[10'hC1] = 8'hB4;
	run(8'h39, 16'h2, 32'hC0, 8'h0, 16'h6, 32'hB0);
	res(32'h2, 32'hC0, 32'h0, 32'hB6, 4'h0);
	run(8'h39, 16'h0, 32'hC0, 8'h0, 16'h6, 32'hB0);
	res(32'h0, 32'hC0, 32'h6, 32'hB0, 4'h4);
	run(8'h39, 16'h2, 32'hC0, 8'h0, 16'h0, 32'hB0);
	res(32'h2, 32'hC0, 32'h0, 32'hB0, 4'h0);
	$display("test match done");
	results;
end
endmodule // test_string_engine
